// ---- rtl/rx_sys_out.v ----
// How it works
// - Master mode: link data changes on own clock
// - Slave mode: own clock or link 1 clock
// - Multiplexed mode: combined data alternates links bytewise
// - Combined data changes on combined clock edge
// - Signaling in b5-b8, aligned with channel data
// - Master mode: link signaling changes on own clock
// - Combined signaling interleaved bytewise, timeslot aligned
// - Combined signaling changes on combined clock edge
// - Master clock gapped 1.544 or 2.048 MHz
`timescale 1ns/1ps
`include "rx_sys_out_consts.vh"

// Small flip-flop FIFO with valid and ready on both sides.
module rx_word_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 4,
  parameter PTR_BITS = 2
) (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Filling side
  input wire [WIDTH-1:0] in_word,
  input wire in_valid,
  output reg in_ready,
  // Draining side
  output wire [WIDTH-1:0] out_word,
  output reg out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [PTR_BITS-1:0] wr_ptr;
  reg [PTR_BITS-1:0] rd_ptr;
  reg [PTR_BITS:0] fill;
  wire push;
  wire pop;
  wire [PTR_BITS:0] next_fill;
  integer i;

  // A word moves on each side only when both valid and ready are high.
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign next_fill = fill + {{PTR_BITS{1'b0}}, push} -
    {{PTR_BITS{1'b0}}, pop};
  assign out_word = store[rd_ptr];

  // Pointers, fill level and registered full and empty flags.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= {PTR_BITS{1'b0}};
      rd_ptr <= {PTR_BITS{1'b0}};
      fill <= {(PTR_BITS+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      fill <= next_fill;
      in_ready <= (next_fill != DEPTH[PTR_BITS:0]);
      out_valid <= (next_fill != {(PTR_BITS+1){1'b0}});
    end
  end

  // Storage is written without reset; only the pointers, fill level and flags need one.
  always @(posedge mclk) begin
    for (i = 0; i < DEPTH; i = i + 1) begin
      if (push && (wr_ptr == i[PTR_BITS-1:0])) begin
        store[i] <= in_word;
      end
    end
  end
endmodule // rx_word_fifo

// Receive system-side output stage for two links.
module rx_sys_out (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  // Mode straps, held steady while running
  input wire mux_mode,
  input wire clock_master,
  input wire slave_clock_share_select,
  input wire e1_mode,
  // Link 1 payload from the framer
  input wire [7:0] link1_payload_data,
  input wire [3:0] link1_payload_sig,
  input wire link1_payload_valid,
  output wire link1_payload_ready,
  // Link 2 payload from the framer
  input wire [7:0] link2_payload_data,
  input wire [3:0] link2_payload_sig,
  input wire link2_payload_valid,
  output wire link2_payload_ready,
  // Link 1 clock pin, also the combined clock input
  input wire link1_rx_sys_clock_in,
  output wire link1_rx_sys_clock_out,
  output wire link1_rx_sys_clock_oe,
  // Link 2 clock pin
  input wire link2_rx_sys_clock_in,
  output wire link2_rx_sys_clock_out,
  output wire link2_rx_sys_clock_oe,
  // Combined frame start pulse, active high
  input wire combined_rx_frame_pulse,
  // Serial outputs
  output wire link1_rx_sys_data_out,
  output wire link2_rx_sys_data_out,
  output wire link1_rx_signaling_out,
  output wire link2_rx_signaling_out,
  output wire combined_rx_sys_data_out,
  output wire combined_rx_signaling_out
);
  localparam WORD_BITS = `BYTE_BITS + `SIG_BITS;

  // Per-link state, index 0 is link 1.
  reg [2:0] clk_sync [0:1];
  reg [2:0] fp_sync;
  reg [`NCO_BITS-1:0] phase [0:1];
  reg [1:0] clk_drive;
  reg clk_oe;
  reg [7:0] data_shift [0:1];
  reg [7:0] sig_shift [0:1];
  reg [2:0] bit_count [0:1];
  reg next_from_link2;
  wire [WORD_BITS-1:0] fifo_word [0:1];
  wire [1:0] fifo_valid;
  reg [1:0] fifo_pop;
  wire [1:0] pin_edge;
  reg [1:0] tick;
  reg [1:0] nco_wrap;
  reg [`NCO_BITS:0] phase_sum [0:1];
  reg [`NCO_BITS-1:0] nco_inc;
  reg frame_start;
  reg pick2;
  integer n;

  // True when a serializer is at a byte boundary and must fetch a word.
  function at_boundary;
    input [2:0] count;
    begin
      at_boundary = (count == 3'h0);
    end
  endfunction

  // One buffer per link absorbs framer bursts against the slower pins.
  rx_word_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(`FIFO_DEPTH),
    .PTR_BITS(2)
  ) fifo_link1 (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_word({link1_payload_data, link1_payload_sig}),
    .in_valid(link1_payload_valid),
    .in_ready(link1_payload_ready),
    .out_word(fifo_word[0]),
    .out_valid(fifo_valid[0]),
    .out_ready(fifo_pop[0])
  );

  rx_word_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(`FIFO_DEPTH),
    .PTR_BITS(2)
  ) fifo_link2 (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_word({link2_payload_data, link2_payload_sig}),
    .in_valid(link2_payload_valid),
    .in_ready(link2_payload_ready),
    .out_word(fifo_word[1]),
    .out_valid(fifo_valid[1]),
    .out_ready(fifo_pop[1])
  );

  // Pin clocks and the frame pulse pass two flip-flops; the third stage
  // only serves the rising-edge detector.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clk_sync[0] <= 3'h0;
      clk_sync[1] <= 3'h0;
      fp_sync <= 3'h0;
    end else begin
      clk_sync[0] <= {clk_sync[0][1:0], link1_rx_sys_clock_in};
      clk_sync[1] <= {clk_sync[1][1:0], link2_rx_sys_clock_in};
      fp_sync <= {fp_sync[1:0], combined_rx_frame_pulse};
    end
  end

  // Rising edge of each pin clock is the active edge.
  assign pin_edge[0] = clk_sync[0][1] & ~clk_sync[0][2];
  assign pin_edge[1] = clk_sync[1][1] & ~clk_sync[1][2];

  // Phase step, rising edges and the active edge of each serializer.
  always @* begin
    nco_inc = e1_mode ? `NCO_INC_E1 : `NCO_INC_T1;
    frame_start = 1'b0;
    for (n = 0; n < 2; n = n + 1) begin
      phase_sum[n] = {1'b0, phase[n]} + {1'b0, nco_inc};
      nco_wrap[n] = phase_sum[n][`NCO_BITS] & ~clk_drive[n] &
        (fifo_valid[n] | ~at_boundary(bit_count[n]));
    end
    if (mux_mode) begin
      tick[0] = pin_edge[0];
      tick[1] = 1'b0;
      frame_start = pin_edge[0] & fp_sync[1];
    end else if (clock_master) begin
      tick = nco_wrap;
    end else begin
      tick[0] = pin_edge[0];
      tick[1] = slave_clock_share_select ? pin_edge[0] : pin_edge[1];
    end
    // Source of the next combined byte: link 1 first after a frame start.
    pick2 = mux_mode & next_from_link2 & ~frame_start;
    fifo_pop = 2'b00;
    if (tick[0] && (at_boundary(bit_count[0]) || frame_start)) begin
      if (pick2) begin
        fifo_pop[1] = fifo_valid[1];
      end else begin
        fifo_pop[0] = fifo_valid[0];
      end
    end
    if (tick[1] && at_boundary(bit_count[1])) begin
      fifo_pop[1] = fifo_valid[1];
    end
  end

  // Master clock generator: toggles on accumulator overflow and stalls
  // low at a byte boundary with no word ready, giving a gapped clock.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase[0] <= {`NCO_BITS{1'b0}};
      phase[1] <= {`NCO_BITS{1'b0}};
      clk_drive <= 2'b00;
      clk_oe <= 1'b0;
    end else begin
      clk_oe <= clock_master & ~mux_mode;
      for (n = 0; n < 2; n = n + 1) begin
        phase[n] <= phase_sum[n][`NCO_BITS-1:0];
        if (!clock_master || mux_mode) begin
          clk_drive[n] <= 1'b0;
        end else if (phase_sum[n][`NCO_BITS] &&
            (clk_drive[n] || nco_wrap[n])) begin
          clk_drive[n] <= ~clk_drive[n];
        end
      end
    end
  end

  // Serializers: load a channel byte at the boundary, else shift MSB
  // (b1) first. Signaling rides in b5 to b8 of the same timeslot.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (n = 0; n < 2; n = n + 1) begin
        data_shift[n] <= `IDLE_DATA;
        sig_shift[n] <= {`SIG_PAD, `IDLE_SIG};
        bit_count[n] <= 3'h0;
      end
      next_from_link2 <= 1'b0;
    end else begin
      for (n = 0; n < 2; n = n + 1) begin
        if (tick[n]) begin
          if (at_boundary(bit_count[n]) || (n == 0 && frame_start)) begin
            bit_count[n] <= `BIT_COUNT_LAST;
            if (fifo_pop[n == 0 && pick2 ? 1 : n]) begin
              data_shift[n] <= fifo_word[n == 0 && pick2 ? 1 : n]
                [WORD_BITS-1:`SIG_BITS];
              sig_shift[n] <= {`SIG_PAD,
                fifo_word[n == 0 && pick2 ? 1 : n][`SIG_BITS-1:0]};
            end else begin
              data_shift[n] <= `IDLE_DATA;
              sig_shift[n] <= {`SIG_PAD, `IDLE_SIG};
            end
            if (n == 0) begin
              next_from_link2 <= mux_mode & ~pick2;
            end
          end else begin
            bit_count[n] <= bit_count[n] - 3'h1;
            data_shift[n] <= {data_shift[n][6:0], 1'b1};
            sig_shift[n] <= {sig_shift[n][6:0], 1'b0};
          end
        end
      end
    end
  end

  // Pins come straight from the shift registers and clock flip-flops.
  // Link 1 and the combined stream share serializer 0, as they share pins.
  assign link1_rx_sys_data_out = data_shift[0][7];
  assign link2_rx_sys_data_out = data_shift[1][7];
  assign link1_rx_signaling_out = sig_shift[0][7];
  assign link2_rx_signaling_out = sig_shift[1][7];
  assign combined_rx_sys_data_out = data_shift[0][7];
  assign combined_rx_signaling_out = sig_shift[0][7];
  assign link1_rx_sys_clock_out = clk_drive[0];
  assign link2_rx_sys_clock_out = clk_drive[1];
  assign link1_rx_sys_clock_oe = clk_oe;
  assign link2_rx_sys_clock_oe = clk_oe;
endmodule // rx_sys_out

// ---- rtl/rx_sys_out_consts.vh ----
`ifndef RX_SYS_OUT_CONSTS_VH
`define RX_SYS_OUT_CONSTS_VH

// Core clock rate in kHz (40 MHz, 25 ns period).
`define MCLK_KHZ 40000
// Master-mode link clock rates in kHz.
`define T1_CLOCK_KHZ 1544
`define E1_CLOCK_KHZ 2048
// Width of the phase accumulator that paces the master-mode clocks.
`define NCO_BITS 16
// The accumulator toggles the clock on overflow, so it steps at twice the
// clock rate: rate * 2 * 65536 / 40000, rounded down, at accumulator width.
`define NCO_INC_T1 16'h13C3
`define NCO_INC_E1 16'h1A36
// Channel byte layout and idle fill.
`define BYTE_BITS 8
`define SIG_BITS 4
`define BIT_COUNT_LAST 3'h7
`define IDLE_DATA 8'hFF
`define IDLE_SIG 4'h0
// Upper nibble (b1 to b4) of a signaling byte; b5 to b8 carry the bits.
`define SIG_PAD 4'h0
// Output buffer depth per link.
`define FIFO_DEPTH 4

`endif

// ---- testbench/backplane_model.sv ----
`timescale 1ns/1ps
// Backplane side: slave clocks that rest low between bursts, frame pulse.
module backplane_model (
  // Controls from the bench
  input wire run1,
  input wire run2,
  input wire frame_req,
  // Pins towards the block
  output reg clk1 = 1'b0,
  output reg clk2 = 1'b0,
  output reg frame_pulse = 1'b0
);
  reg ran = 1'b0;
  // Link 1 clock; the first edge of a burst carries the frame pulse.
  // The combined clock runs at 5 MHz, above its line rates, with 100 ns
  // phases that the core clock can still find after synchronisation.
  always begin
    if (run1) begin
      frame_pulse = frame_req && !ran;
      ran = 1'b1;
      #100 clk1 = 1'b1;
      #100 clk1 = 1'b0;
      frame_pulse = 1'b0;
    end else begin
      ran = 1'b0;
      #7;
    end
  end
  // Link 2 clock, with its own phase.
  always begin
    if (run2) begin
      #100 clk2 = 1'b1;
      #100 clk2 = 1'b0;
    end else begin
      #11;
    end
  end
endmodule // backplane_model

// ---- testbench/rx_sys_out_props.sv ----
`timescale 1ns/1ps
// Checks that the serial pins move only with their timing clocks.
module rx_sys_out_props (
  // Clock, reset and straps
  input wire mclk,
  input wire reset_n,
  input wire mux_mode,
  input wire clock_master,
  input wire slave_clock_share_select,
  // Clock pins
  input wire link1_rx_sys_clock_in,
  input wire link2_rx_sys_clock_in,
  input wire link1_rx_sys_clock_out,
  input wire link2_rx_sys_clock_out,
  input wire link1_rx_sys_clock_oe,
  // Serial outputs
  input wire link1_rx_sys_data_out,
  input wire link2_rx_sys_data_out,
  input wire link1_rx_signaling_out,
  input wire link2_rx_signaling_out,
  input wire combined_rx_sys_data_out,
  input wire combined_rx_signaling_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Mode decodes used by the checks below.
  wire mst = clock_master && !mux_mode;
  wire slv = !clock_master && !mux_mode;
  wire shr = slave_clock_share_select;
  // Master mode bits change in the cycle the link clock rises.
  a_m1_data: assert property (mst && $changed(link1_rx_sys_data_out)
    |-> $rose(link1_rx_sys_clock_out)) else $error("Link 1 data off clock.");
  a_m2_data: assert property (mst && $changed(link2_rx_sys_data_out)
    |-> $rose(link2_rx_sys_clock_out)) else $error("Link 2 data off clock.");
  a_m1_sig: assert property (mst && $changed(link1_rx_signaling_out)
    |-> $rose(link1_rx_sys_clock_out)) else $error("Link 1 sig off clock.");
  a_m2_sig: assert property (mst && $changed(link2_rx_signaling_out)
    |-> $rose(link2_rx_sys_clock_out)) else $error("Link 2 sig off clock.");
  // The clock pin is driven exactly in master mode, one cycle late, once
  // the enable flop has had an edge out of reset.
  a_oe_follow: assert property ($past(reset_n) |->
    link1_rx_sys_clock_oe == $past(mst)) else $error("Clock enable wrong.");
  // Slave link 2 data and multiplexed bits change while the chosen pin clock is high.
  a_s2_own: assert property (slv && !shr && $changed(link2_rx_sys_data_out)
    |-> $past(link2_rx_sys_clock_in)) else $error("Link 2 own clock.");
  a_s2_share: assert property (slv && shr && $changed(link2_rx_sys_data_out)
    |-> $past(link1_rx_sys_clock_in)) else $error("Link 2 shared clock.");
  a_mux_data: assert property (mux_mode && $changed(combined_rx_sys_data_out)
    |-> $past(link1_rx_sys_clock_in)) else $error("Combined data off clock.");
  a_mux_sig: assert property (mux_mode && $changed(combined_rx_signaling_out)
    |-> $past(link1_rx_sys_clock_in)) else $error("Combined sig off clock.");
  // Main scenarios reached.
  c_mux: cover property (mux_mode && $rose(link1_rx_sys_clock_in));
  c_share: cover property (slv && shr && $changed(link2_rx_sys_data_out));
  c_master: cover property (mst && $rose(link1_rx_sys_clock_out));
endmodule // rx_sys_out_props

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
// Self-checking bench for the receive system-side output stage.
module testbench;
  reg mclk = 1'b0;
  reg reset_n = 1'b0;
  reg mux_mode = 1'b0;
  reg clock_master = 1'b0;
  reg share = 1'b0;
  reg e1_mode = 1'b0;
  reg [11:0] w1 = 12'h000;
  reg [11:0] w2 = 12'h000;
  reg v1 = 1'b0;
  reg v2 = 1'b0;
  reg run1 = 1'b0;
  reg run2 = 1'b0;
  reg frame_req = 1'b0;
  wire rdy1, rdy2, co1, co2, oe1, oe2, bc1, bc2, fp, d1, d2, s1, s2, cd, cs;
  wire pin1 = oe1 ? co1 : bc1;
  wire pin2 = oe2 ? co2 : bc2;
  wire mon2_clk = share ? pin1 : pin2;
  integer n_mismatch = 0;
  integer checked = 0;
  integer nb1 = 0, nb2 = 0, bit1 = 0, bit2 = 0, t0 = 0, t1 = 0, i;
  reg [15:0] rnd = 16'h0011;
  reg [7:0] sd1, ss1, sd2, ss2;
  reg [11:0] q1[$];
  reg [11:0] q2[$];
  always #12.5 mclk = ~mclk;
  backplane_model backplane_model_inst (.run1(run1), .run2(run2),
    .frame_req(frame_req), .clk1(bc1), .clk2(bc2), .frame_pulse(fp));
  rx_sys_out rx_sys_out_inst (.mclk(mclk), .reset_n(reset_n),
    .mux_mode(mux_mode), .clock_master(clock_master),
    .slave_clock_share_select(share), .e1_mode(e1_mode),
    .link1_payload_data(w1[11:4]), .link1_payload_sig(w1[3:0]),
    .link1_payload_valid(v1), .link1_payload_ready(rdy1),
    .link2_payload_data(w2[11:4]), .link2_payload_sig(w2[3:0]),
    .link2_payload_valid(v2), .link2_payload_ready(rdy2),
    .link1_rx_sys_clock_in(pin1), .link1_rx_sys_clock_out(co1),
    .link1_rx_sys_clock_oe(oe1), .link2_rx_sys_clock_in(pin2),
    .link2_rx_sys_clock_out(co2), .link2_rx_sys_clock_oe(oe2),
    .combined_rx_frame_pulse(fp), .link1_rx_sys_data_out(d1),
    .link2_rx_sys_data_out(d2), .link1_rx_signaling_out(s1),
    .link2_rx_signaling_out(s2), .combined_rx_sys_data_out(cd),
    .combined_rx_signaling_out(cs));
  function [15:0] lfsr(input [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Next expected serial byte pair; an empty queue means the idle fill.
  function [15:0] pop(input integer k);
    reg [11:0] w;
    begin
      w = 12'hFF0;
      if (k == 1 && q1.size() > 0) w = q1.pop_front();
      if (k == 2 && q2.size() > 0) w = q2.pop_front();
      pop = {w[11:4], 4'h0, w[3:0]};
    end
  endfunction
  task check(input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      if (n_mismatch == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Link 1 or combined bytes, bit by bit on the falling clock edge.
  always @(negedge pin1) if (reset_n) begin
    sd1 = {sd1[6:0], mux_mode ? cd : d1};
    ss1 = {ss1[6:0], mux_mode ? cs : s1};
    if (bit1 == 0 && nb1 == 0) t0 = $time;
    bit1 = bit1 + 1;
    if (bit1 == 8) begin
      bit1 = 0;
      nb1 = nb1 + 1;
      t1 = $time;
      check({sd1, ss1}, pop(1));
    end
  end
  // Link 2 bytes on its own or the shared clock.
  always @(negedge mon2_clk) if (reset_n) begin
    sd2 = {sd2[6:0], d2};
    ss2 = {ss2[6:0], s2};
    bit2 = bit2 + 1;
    if (bit2 == 8) begin
      bit2 = 0;
      nb2 = nb2 + 1;
      check({sd2, ss2}, pop(2));
    end
  end
  // Offers random words on both links until link 1's buffer refuses, six words at most.
  task fill;
    integer a;
    begin
      a = 0;
      while (rdy1 === 1'b1 && a < 6) begin
        rnd = lfsr(rnd);
        w1 = rnd[11:0];
        rnd = lfsr(rnd);
        w2 = rnd[11:0];
        v1 = 1'b1;
        v2 = 1'b1;
        q1.push_back(w1);
        if (mux_mode) q1.push_back(w2);
        else q2.push_back(w2);
        a = a + 1;
        @(posedge mclk);
        #2;
      end
      v1 = 1'b0;
      v2 = 1'b0;
      if (!clock_master) check(a[15:0], 16'h0004);
      if (!clock_master) check({14'h0000, rdy1, rdy2}, 16'h0000);
    end
  endtask
  // One mode: reset, fill, run the clocks, count and time the bytes.
  task phase(input [3:0] m);
    integer want, expt;
    begin
      #2 reset_n = 1'b0;
      {mux_mode, clock_master, share, e1_mode} = m;
      repeat (20) @(posedge mclk);
      #2 reset_n = 1'b1;
      nb1 = 0;
      nb2 = 0;
      bit1 = 0;
      bit2 = 0;
      q1.delete();
      q2.delete();
      want = m[2] ? 4 : 6;
      repeat (2) @(posedge mclk);
      #2 fill;
      check({14'h0000, oe1, oe2}, m[2] ? 16'h0003 : 16'h0000);
      run1 = !m[2];
      run2 = !m[2] && !m[3] && !m[1];
      frame_req = m[3];
      for (i = 0; i < 4000 && (nb1 < want || (!m[3] && nb2 < want)); i++)
        @(posedge mclk);
      check(nb1[15:0], want[15:0]);
      expt = e1_mode ? 15137 : 20078;
      if (m[2]) check({15'h0000, t1 - t0 > expt * 97 / 100 &&
        t1 - t0 < expt * 103 / 100}, 16'h0001);
      run1 = 1'b0;
      run2 = 1'b0;
      frame_req = 1'b0;
    end
  endtask
  // Modes: slave own clock, slave shared clock, multiplexed, master T1, E1.
  initial begin
    phase(4'h0);
    phase(4'h2);
    phase(4'h8);
    phase(4'h4);
    phase(4'h5);
    wrap_up;
  end
  // Cuts a hang short.
  initial begin
    #1000000;
    n_mismatch = n_mismatch + 1;
    wrap_up;
  end
endmodule // testbench
bind rx_sys_out rx_sys_out_props props_inst (.*);
